// ==== verilog/store_sub_exec_defines.svh ====
/*
 opcode values, prefixed opcode values, cycle counts and vector address
 for the store, subtract, trap and stop execution unit.
 assumes nothing: definitions only.
*/
`ifndef STORE_SUB_EXEC_DEFINES_SVH
`define STORE_SUB_EXEC_DEFINES_SVH
`define OP_PREFIX      8'h9e
`define OP_ACC_ST_DIR  8'hb7
`define OP_ACC_ST_EXT  8'hc7
`define OP_ACC_ST_IX2  8'hd7
`define OP_ACC_ST_IX1  8'he7
`define OP_ACC_ST_IX   8'hf7
`define OP_ACC_ST_STK2 8'hd7
`define OP_ACC_ST_STK1 8'he7
`define OP_PAIR_ST_DIR 8'h35
`define OP_PAIR_ST_EXT 8'h96
`define OP_PAIR_ST_STK1 8'hff
`define OP_XLO_ST_DIR  8'hbf
`define OP_XLO_ST_EXT  8'hcf
`define OP_XLO_ST_IX2  8'hdf
`define OP_XLO_ST_IX1  8'hef
`define OP_XLO_ST_IX   8'hff
`define OP_XLO_ST_STK2 8'hdf
`define OP_XLO_ST_STK1 8'hef
`define OP_SUB_IMM     8'ha0
`define OP_SUB_DIR     8'hb0
`define OP_SUB_EXT     8'hc0
`define OP_SUB_IX2     8'hd0
`define OP_SUB_IX1     8'he0
`define OP_SUB_IX      8'hf0
`define OP_SUB_STK2    8'hd0
`define OP_SUB_STK1    8'he0
`define OP_TRAP        8'h83
`define OP_STOP        8'h8e
`define CYC_TRAP       4'hb
`define CYC_STOP       4'h2
`define TRAP_VEC_HI    16'hfffc
`define TRAP_VEC_LO    16'hfffd
`define RST_STACK      16'h00ff
`endif

// ==== verilog/store_sub_exec_pkg.sv ====
/*
 types for the store, subtract, trap and stop execution unit.
 assumes the defines header is compiled alongside.
*/
package store_sub_exec_pkg;
   typedef enum logic [2:0] {M_DIR, M_EXT, M_IX2, M_IX1, M_IX, M_STK2, M_STK1, M_IMM} addr_mode_t;
   typedef enum logic [2:0] {K_NONE, K_ACC_ST, K_PAIR_ST, K_XLO_ST, K_SUB} op_kind_t;
   typedef enum logic [3:0] {S_FETCH, S_OP2, S_ADDR1, S_ADDR2, S_EXEC, S_WR2, S_READ, S_TRAP, S_STOPPED,
                             S_VEC1, S_VEC2} cpu_state_t;
endpackage

// ==== verilog/store_sub_exec.sv ====
/*
 execution unit for accumulator, index-low and index-pair stores,
 subtract, software trap and stop on an 8-bit accumulator cpu.
 assumes an asynchronous-read memory bus: read data is valid in the same
 cycle the address is presented; writes take effect on the clock edge.
 opcodes 00-9f ending in 0, 7 or f run as direct-mode subtract or stores; opcodes not among those or the header's defines are one-cycle no-operations.
*/
`timescale 1ns/1ps
`default_nettype none
`include "store_sub_exec_defines.svh"
module store_sub_exec
(
   input  wire logic                          clk_i,
   input  wire logic                          sys_rst_i,
   input  wire logic [7:0]                    mem_rdata_i,
   output logic      [15:0]                   mem_addr_o,
   output logic      [7:0]                    mem_wdata_o,
   output logic                               mem_we_o,
   output logic                               stopped_o,
   output logic      [7:0]                    acc_o,
   output logic      [15:0]                   index_o,
   output logic      [7:0]                    cond_o,
   output logic      [15:0]                   pc_o,
   output logic      [15:0]                   stack_o,
   output store_sub_exec_pkg::cpu_state_t     state_o
);
// Summary of operation
// - accumulator store writes a, sets v0 nz
// - accumulator store seven modes, cycles 3443254
// - index pair store high then low, flags
// - index pair store direct, extended, stack forms
// - stop clears mask then halts processing
// - index low store writes x, flags, modes
// - subtract updates a and v n z c
// - trap pushes pc low, high, x, a, flags
// - trap sets mask, loads vector, eleven cycles
   import store_sub_exec_pkg::*;

   // flag layout: v 1 1 h i n z c
   typedef struct packed
   {
      cpu_state_t  st;
      op_kind_t    kind;
      addr_mode_t  mode;
      logic        pre;
      logic [7:0]  a;
      logic [15:0] hx;
      logic [7:0]  cc;
      logic [15:0] pc;
      logic [15:0] stk;
      logic [15:0] ea;
      logic [3:0]  cnt;
      logic [3:0]  left;
      logic [7:0]  wdata;
      logic        we;
      logic [15:0] addr;
   } state_t;

   state_t s_q, s_d;
   logic [8:0] diff;
   logic [7:0] res8;

   function automatic logic [3:0] cycles_of(op_kind_t k, addr_mode_t m);
      logic [3:0] c;
      c = 4'h1;
      if (k == K_PAIR_ST)
         c = (m == M_DIR) ? 4'h4 : 4'h5;
      else
      begin
         case (m)
            M_IMM: c = 4'h2;
            M_DIR: c = 4'h3;
            M_EXT: c = 4'h4;
            M_IX2: c = 4'h4;
            M_IX1: c = 4'h3;
            M_IX:  c = 4'h2;
            M_STK2: c = 4'h5;
            M_STK1: c = 4'h4;
            default: c = 4'h1;
         endcase
      end
      return c;
   endfunction

   always_comb
   begin
      s_d = s_q;
      s_d.we = 1'b0;
      s_d.cnt = s_q.cnt + 4'h1;
      diff = {1'b0, s_q.a} - {1'b0, mem_rdata_i};
      res8 = 8'h00;
      case (s_q.st)
         S_FETCH:
         begin
            s_d.cnt = 4'h1;
            s_d.pre = 1'b0;
            s_d.kind = K_NONE;
            s_d.addr = s_q.pc + 16'h0001;
            s_d.pc = s_q.pc + 16'h0001;
            s_d.st = S_OP2;
         end
         S_OP2:
         begin
            // opcode sampled at the address issued last cycle
            s_d.st = S_ADDR1;
            s_d.mode = M_DIR;
            if (mem_rdata_i == `OP_PREFIX && !s_q.pre)
            begin
               s_d.pre = 1'b1;
               s_d.addr = s_q.pc + 16'h0001;
               s_d.pc = s_q.pc + 16'h0001;
               s_d.st = S_OP2;
            end
            else if (!s_q.pre && mem_rdata_i == `OP_TRAP)
            begin
               s_d.pc = s_q.pc + 16'h0001;
               s_d.st = S_TRAP;
            end
            else if (!s_q.pre && mem_rdata_i == `OP_STOP)
            begin
               s_d.cc[3] = 1'b0;
               s_d.st = S_STOPPED;
            end
            else
            begin
               case (mem_rdata_i[3:0])
                  4'h7: s_d.kind = K_ACC_ST;
                  4'hf: s_d.kind = K_XLO_ST;
                  4'h0: s_d.kind = K_SUB;
                  default: s_d.kind = K_NONE;
               endcase
               case (mem_rdata_i[7:4])
                  4'ha: s_d.mode = M_IMM;
                  4'hb: s_d.mode = M_DIR;
                  4'hc: s_d.mode = M_EXT;
                  4'hd: s_d.mode = s_q.pre ? M_STK2 : M_IX2;
                  4'he: s_d.mode = s_q.pre ? M_STK1 : M_IX1;
                  4'hf: s_d.mode = M_IX;
                  default: s_d.mode = M_DIR;
               endcase
               // the prefix kill runs first so the prefixed pair store survives it
               if (s_q.pre && mem_rdata_i[7:4] inside {4'ha, 4'hb, 4'hc, 4'hf})
                  s_d.kind = K_NONE;
               if (!s_q.pre && mem_rdata_i == `OP_PAIR_ST_DIR)
               begin
                  s_d.kind = K_PAIR_ST;
                  s_d.mode = M_DIR;
               end
               if (!s_q.pre && mem_rdata_i == `OP_PAIR_ST_EXT)
               begin
                  s_d.kind = K_PAIR_ST;
                  s_d.mode = M_EXT;
               end
               if (s_q.pre && mem_rdata_i == `OP_PAIR_ST_STK1)
               begin
                  s_d.kind = K_PAIR_ST;
                  s_d.mode = M_STK1;
               end
               if (s_d.kind == K_ACC_ST && s_d.mode == M_IMM)
                  s_d.kind = K_NONE;
               if (s_d.kind == K_XLO_ST && s_d.mode == M_IMM)
                  s_d.kind = K_NONE;
               s_d.left = cycles_of(s_d.kind, s_d.mode);
               if (s_d.kind == K_NONE)
               begin
                  s_d.addr = s_q.pc + 16'h0001;
                  s_d.st = S_FETCH;
               end
               else if (s_d.mode == M_IX)
               begin
                  s_d.ea = s_q.hx;
                  s_d.addr = s_q.hx;
                  s_d.st = S_EXEC;
               end
               else
               begin
                  s_d.addr = s_q.pc + 16'h0001;
                  s_d.pc = s_q.pc + 16'h0001;
               end
            end
         end
         S_ADDR1:
         begin
            s_d.ea = {8'h00, mem_rdata_i};
            s_d.st = S_EXEC;
            case (s_q.mode)
               M_IMM:
               begin
                  s_d.ea = s_q.addr;
               end
               M_IX1: s_d.ea = s_q.hx + {8'h00, mem_rdata_i};
               M_STK1: s_d.ea = s_q.stk + {8'h00, mem_rdata_i};
               M_EXT, M_IX2, M_STK2:
               begin
                  s_d.ea = {mem_rdata_i, 8'h00};
                  s_d.addr = s_q.pc + 16'h0001;
                  s_d.pc = s_q.pc + 16'h0001;
                  s_d.st = S_ADDR2;
               end
               default: s_d.ea = {8'h00, mem_rdata_i};
            endcase
            if (s_q.mode != M_EXT && s_q.mode != M_IX2 && s_q.mode != M_STK2)
               s_d.addr = s_d.ea;
         end
         S_ADDR2:
         begin
            s_d.ea = {s_q.ea[15:8], mem_rdata_i};
            if (s_q.mode == M_IX2)
               s_d.ea = s_q.hx + {s_q.ea[15:8], mem_rdata_i};
            if (s_q.mode == M_STK2)
               s_d.ea = s_q.stk + {s_q.ea[15:8], mem_rdata_i};
            s_d.addr = s_d.ea;
            s_d.st = S_EXEC;
         end
         S_EXEC:
         begin
            // pc already names the last byte of this instruction; fetch adds one
            s_d.st = S_FETCH;
            s_d.addr = s_q.pc + 16'h0001;
            case (s_q.kind)
               K_ACC_ST, K_XLO_ST:
               begin
                  res8 = (s_q.kind == K_ACC_ST) ? s_q.a : s_q.hx[7:0];
                  s_d.wdata = res8;
                  s_d.we = 1'b1;
                  s_d.addr = s_q.ea;
                  s_d.cc[7] = 1'b0;
                  s_d.cc[2] = res8[7];
                  s_d.cc[1] = (res8 == 8'h00);
               end
               K_PAIR_ST:
               begin
                  s_d.wdata = s_q.hx[15:8];
                  s_d.we = 1'b1;
                  s_d.addr = s_q.ea;
                  s_d.cc[7] = 1'b0;
                  s_d.cc[2] = s_q.hx[15];
                  s_d.cc[1] = (s_q.hx == 16'h0000);
                  s_d.st = S_WR2;
               end
               K_SUB:
               begin
                  s_d.a = diff[7:0];
                  s_d.cc[7] = (s_q.a[7] ^ mem_rdata_i[7]) & (s_q.a[7] ^ diff[7]);
                  s_d.cc[2] = diff[7];
                  s_d.cc[1] = (diff[7:0] == 8'h00);
                  s_d.cc[0] = diff[8];
                  s_d.addr = s_q.pc + 16'h0001;
               end
               default: s_d.st = S_FETCH;
            endcase
         end
         S_WR2:
         begin
            s_d.wdata = s_q.hx[7:0];
            s_d.we = 1'b1;
            s_d.addr = s_q.ea + 16'h0001;
            s_d.st = S_FETCH;
         end
         S_TRAP:
         begin
            // cnt 2..6 push pc low, pc high, x, a, flags with post-decrement
            s_d.we = 1'b1;
            s_d.addr = s_q.stk;
            s_d.stk = s_q.stk - 16'h0001;
            case (s_q.cnt)
               4'h2: s_d.wdata = s_q.pc[7:0];
               4'h3: s_d.wdata = s_q.pc[15:8];
               4'h4: s_d.wdata = s_q.hx[7:0];
               4'h5: s_d.wdata = s_q.a;
               default: s_d.wdata = s_q.cc;
            endcase
            if (s_q.cnt == 4'h6)
            begin
               s_d.cc[3] = 1'b1;
               s_d.st = S_VEC1;
            end
         end
         S_VEC1:
         begin
            // two idle bus cycles pad the trap to its full length
            s_d.addr = `TRAP_VEC_HI;
            if (s_q.cnt == 4'h9)
               s_d.st = S_VEC2;
         end
         S_VEC2:
         begin
            if (s_q.addr == `TRAP_VEC_HI)
            begin
               s_d.pc = {mem_rdata_i, 8'h00};
               s_d.addr = `TRAP_VEC_LO;
            end
            else
            begin
               s_d.pc = {s_q.pc[15:8], mem_rdata_i};
               s_d.addr = {s_q.pc[15:8], mem_rdata_i};
               s_d.st = S_FETCH;
               s_d.pc = {s_q.pc[15:8], mem_rdata_i} - 16'h0001;
            end
         end
         S_STOPPED: s_d.st = S_STOPPED;
         default: s_d.st = S_FETCH;
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         s_q <= '{st: S_FETCH, kind: K_NONE, mode: M_DIR, cc: 8'h68, stk: `RST_STACK, pc: 16'hffff, default: '0};
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // pc holds the address of the last fetched byte; fetch uses pc + 1
   assign mem_addr_o  = s_q.addr;
   assign mem_wdata_o = s_q.wdata;
   assign mem_we_o    = s_q.we;
   assign stopped_o   = (s_q.st == S_STOPPED);
   assign acc_o       = s_q.a;
   assign index_o     = s_q.hx;
   assign cond_o      = s_q.cc;
   assign pc_o        = s_q.pc;
   assign stack_o     = s_q.stk;
   assign state_o     = s_q.st;

   chk_store_clears_v: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (s_q.st == S_EXEC && s_q.kind == K_ACC_ST) |=> (mem_we_o && mem_wdata_o == $past(s_q.a) && !cond_o[7]))
      else $error("store did not write accumulator");
   chk_store_keeps_c: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (s_q.st == S_EXEC && s_q.kind != K_SUB) |=> (cond_o[0] == $past(cond_o[0]) && cond_o[4] == $past(cond_o[4])))
      else $error("store changed carry or half carry");
   chk_pair_low_next: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (s_q.st == S_EXEC && s_q.kind == K_PAIR_ST) |=> mem_we_o ##1 (mem_we_o && mem_addr_o == $past(mem_addr_o) + 16'h0001))
      else $error("pair store low byte misplaced");
   chk_stop_mask_clr: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      stopped_o |-> !cond_o[3])
      else $error("stopped with mask set");
   chk_low_store_nz: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (s_q.st == S_EXEC && s_q.kind == K_XLO_ST) |=> (cond_o[1] == (mem_wdata_o == 8'h00) && cond_o[2] == mem_wdata_o[7]))
      else $error("index low store flags wrong");
   chk_sub_result: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (s_q.st == S_EXEC && s_q.kind == K_SUB) |=> (acc_o == $past(s_q.a) - $past(mem_rdata_i) && cond_o[1] == (acc_o == 8'h00)))
      else $error("subtract result wrong");
   chk_trap_pushes: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (s_q.st == S_OP2 && mem_rdata_i == `OP_TRAP && !s_q.pre) |=> ##1 (mem_we_o && mem_wdata_o == $past(pc_o[7:0], 1)))
      else $error("trap did not push pc low first");
   chk_trap_sp_dec: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (s_q.st == S_OP2 && mem_rdata_i == `OP_TRAP && !s_q.pre) |=> ##5 (stack_o == $past(stack_o, 5) - 16'h0005))
      else $error("trap stack pointer not lowered by five");
   chk_trap_mask_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (s_q.st == S_TRAP && s_q.cnt == 4'h6) |=> cond_o[3] ##5 (s_q.st == S_FETCH))
      else $error("trap mask or length wrong");
   cov_acc_store: cover property (@(posedge clk_i) disable iff (sys_rst_i) s_q.st == S_EXEC && s_q.kind == K_ACC_ST);
   cov_pair_store: cover property (@(posedge clk_i) disable iff (sys_rst_i) s_q.st == S_WR2);
   cov_trap: cover property (@(posedge clk_i) disable iff (sys_rst_i) s_q.st == S_VEC2);
   cov_stop: cover property (@(posedge clk_i) disable iff (sys_rst_i) stopped_o);
endmodule
`default_nettype wire

// ==== verif/store_sub_exec_mem.sv ====
/*
 behavioural program and data memory on the bus of the store/subtract unit.
 assumes one clock; the bench loads and inspects contents through mem.
*/
`timescale 1ns/1ps
`default_nettype none
module exec_bus_mem
(
   input  wire logic        clk_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        we_i,
   output wire logic [7:0]  rdata_o
);
   logic [7:0] mem [0:65535];
   int         wr_count;

   initial
   begin
      wr_count = 0;
   end

   // the unit registers its address, so the byte is read out in the same cycle it is shown
   assign rdata_o = mem[addr_i];

   always @(posedge clk_i)
   begin
      if (we_i)
      begin
         mem[addr_i] <= wdata_i;
         wr_count    <= wr_count + 1;
      end
   end
endmodule
`default_nettype wire

// ==== verif/store_sub_exec_tb_top.sv ====
/*
 self-checking bench: runs short programs through the execution unit.
 assumes the unit fetches from 0x0000 after reset and halts on stop.
*/
`timescale 1ns/1ps
`default_nettype none
module store_sub_exec_tb_top;
   import store_sub_exec_pkg::*;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [7:0]  rdata;
   logic [15:0] addr;
   logic [7:0]  wdata;
   logic        we;
   logic        stopped;
   logic [7:0]  acc;
   logic [15:0] index;
   logic [7:0]  cond_codes;
   logic [15:0] pc;
   logic [15:0] stack_ptr;
   cpu_state_t  state;
   int          failures = 0;
   int          cmp_count = 0;

   always #5 clk = ~clk;

   exec_bus_mem u_mem (.clk_i(clk), .addr_i(addr), .wdata_i(wdata), .we_i(we), .rdata_o(rdata));

   store_sub_exec u_dut (.clk_i(clk), .sys_rst_i(sys_rst), .mem_rdata_i(rdata), .mem_addr_o(addr),
      .mem_wdata_o(wdata), .mem_we_o(we), .stopped_o(stopped), .acc_o(acc), .index_o(index),
      .cond_o(cond_codes), .pc_o(pc), .stack_o(stack_ptr), .state_o(state));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      begin
         cmp_count++;
         if (seen !== exp)
         begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask

   task automatic stop_test;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, failures);
         if (failures == 0 && cmp_count > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask

   // stop opcode as filler, so a runaway fetch halts instead of wandering
   task automatic clear_mem;
      begin
         for (int i = 0; i < 65536; i++)
            u_mem.mem[i] = 8'h8e;
      end
   endtask

   task automatic prog(input logic [15:0] base, input logic [7:0] b [$]);
      begin
         foreach (b[i])
            u_mem.mem[base + 16'(i)] = b[i];
      end
   endtask

   task automatic run(input int writes);
      int          n;
      logic [15:0] pc_at_halt;
      int          wr_start;
      begin
         wr_start = u_mem.wr_count;
         @(negedge clk);
         sys_rst = 1'b1;
         repeat (12) @(negedge clk);
         check(cond_codes, 8'h68);
         check(stack_ptr, 16'h00ff);
         check({acc, 7'h00, we}, 16'h0000);
         sys_rst = 1'b0;
         n = 0;
         while (stopped !== 1'b1 && n < 400)
         begin
            @(negedge clk);
            n++;
         end
         check(stopped, 1'b1);
         pc_at_halt = pc;
         repeat (20) @(negedge clk);
         check(pc, pc_at_halt);
         check(16'(u_mem.wr_count - wr_start), 16'(writes));
      end
   endtask

   task automatic acc_store_forms;
      logic [15:0] at [$];
      begin
         at = '{16'h0040, 16'h1234, 16'h0150, 16'h0020, 16'h0000, 16'h01ff, 16'h0101};
         clear_mem();
         // leading 9d is an unknown opcode and must be skipped
         prog(16'h0000, '{8'h9d, 8'ha0, 8'h01, 8'hb7, 8'h40, 8'hc7, 8'h12, 8'h34, 8'hd7, 8'h01, 8'h50,
                          8'he7, 8'h20, 8'hf7, 8'h9e, 8'hd7, 8'h01, 8'h00, 8'h9e, 8'he7, 8'h02, 8'h8e});
         run(7);
         foreach (at[i])
            check(u_mem.mem[at[i]], 8'hff);
         check(acc, 8'hff);
         check(cond_codes, 8'h65);
      end
   endtask

   function automatic logic [15:0] sub_expect(input logic [7:0] a, input logic [7:0] m);
      logic [8:0] r;
      logic       v;
      begin
         r = {1'b0, a} - {1'b0, m};
         v = (a[7] & ~m[7] & ~r[7]) | (~a[7] & m[7] & r[7]);
         return {r[7:0], v, 4'b1100, r[7], r[7:0] == 8'h00, r[8]};
      end
   endfunction

   task automatic sub_cases;
      logic [7:0]  m1 [$];
      logic [7:0]  m2 [$];
      logic [15:0] e;
      begin
         m1 = '{8'h01, 8'h80, 8'h00, 8'hff};
         m2 = '{8'h01, 8'h80, 8'h7f, 8'h80};
         foreach (m1[i])
         begin
            clear_mem();
            prog(16'h0000, '{8'ha0, m1[i], 8'hb0, 8'h60, 8'h8e});
            u_mem.mem[16'h0060] = m2[i];
            run(0);
            e = sub_expect(8'h00 - m1[i], m2[i]);
            check(acc, e[15:8]);
            check(cond_codes, e[7:0]);
         end
      end
   endtask

   task automatic index_stores;
      logic [15:0] at [$];
      begin
         at = '{16'h0040, 16'h0041, 16'h1234, 16'h1235, 16'h0104, 16'h0105, 16'h0050, 16'h2345, 16'h0060,
                16'h0102};
         clear_mem();
         foreach (at[i])
            u_mem.mem[at[i]] = 8'haa;
         prog(16'h0000, '{8'ha0, 8'h01, 8'h35, 8'h40, 8'h96, 8'h12, 8'h34, 8'h9e, 8'hff, 8'h05, 8'hbf, 8'h50,
                          8'hcf, 8'h23, 8'h45, 8'hef, 8'h60, 8'h9e, 8'hef, 8'h03, 8'h8e});
         run(10);
         foreach (at[i])
            check(u_mem.mem[at[i]], 8'h00);
         check(index, 16'h0000);
         check(cond_codes, 8'h63);
      end
   endtask

   task automatic trap_sequence;
      logic [15:0] at [$];
      logic [7:0]  ev [$];
      begin
         at = '{16'h00ff, 16'h00fe, 16'h00fd, 16'h00fc, 16'h00fb};
         ev = '{8'h03, 8'h00, 8'h00, 8'hfb, 8'h6d};
         clear_mem();
         foreach (at[i])
            u_mem.mem[at[i]] = 8'h55;
         prog(16'h0000, '{8'ha0, 8'h05, 8'h83});
         prog(16'hfffc, '{8'h20, 8'h00});
         run(5);
         foreach (at[i])
            check(u_mem.mem[at[i]], ev[i]);
         check(stack_ptr, 16'h00fa);
         check(pc[15:8], 8'h20);
         check(cond_codes, 8'h65);
      end
   endtask

   initial
   begin
      acc_store_forms();
      sub_cases();
      index_stores();
      trap_sequence();
      stop_test();
   end

   initial
   begin
      #200000;
      failures++;
      stop_test();
   end
endmodule
`default_nettype wire
